/* src/mbcd_top.sv */
// multi-bank clock divider control: dividers, disables, polarity, lock, test
// assumes all pins are synchronous to pclk and sampled well above the clock rates
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module mbcd_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic vco_clk_level,
   input wire logic ref_clk_level,
   input wire logic loop_return_input,
   input wire mbcd_pkg::mbcd_sel_pair_type [3:0] bank_divide_select,
   input wire mbcd_pkg::mbcd_sel_pair_type [3:0] bank_phase_select,
   input wire logic [3:0] bank_off_request,
   input wire mbcd_pkg::mbcd_sel_pair_type feedback_divide_select,
   input wire mbcd_pkg::mbcd_tri_type feedback_phase_select,
   input wire logic feedback_bank_off_request,
   input wire mbcd_pkg::mbcd_tri_type bank3_polarity_select,
   input wire mbcd_pkg::mbcd_tri_type frequency_range_select,
   input wire mbcd_pkg::mbcd_tri_type output_mode_select,
   output logic [3:0][3:0] bank_out,
   output logic [3:0] bank_oe,
   output logic [1:0] feedback_out,
   output logic feedback_oe,
   output logic lock_flag
);
   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   // level pair to index 0..8, upper select weighs three
   function automatic logic [3:0] pair_idx(input mbcd_pkg::mbcd_tri_type hi,
                                           input mbcd_pkg::mbcd_tri_type lo);
      pair_idx = {2'b00, hi} * 4'h3 + {2'b00, lo};
   endfunction : pair_idx
   // divide ratio from a select pair
   function automatic logic [4:0] div_ratio(input mbcd_pkg::mbcd_sel_pair_type s);
      logic [3:0] i;
      i = pair_idx(s.hi, s.lo);
      if (i < 4'h6)
         div_ratio = {1'b0, i} + 5'h01;
      else if (i == 4'h6)
         div_ratio = 5'h08;
      else if (i == 4'h7)
         div_ratio = 5'h0a;
      else
         div_ratio = 5'h0c;
   endfunction : div_ratio
   // skew in time units; wide banks reach eight and may follow bank1/bank2
   function automatic logic signed [5:0] skew_tu(input mbcd_pkg::mbcd_sel_pair_type s,
                                                 input logic wide,
                                                 input logic signed [5:0] bk1,
                                                 input logic signed [5:0] bk2);
      logic [3:0] i;
      i = pair_idx(s.hi, s.lo);
      if (!wide)
         skew_tu = $signed({2'b00, i}) - 6'sh04;
      else if (i < 4'h3)
         skew_tu = $signed({2'b00, i}) - 6'sh08;
      else if (i == 4'h3)
         skew_tu = bk1;
      else if (i == 4'h4)
         skew_tu = 6'sh00;
      else if (i == 4'h5)
         skew_tu = bk2;
      else
         skew_tu = $signed({2'b00, i});
   endfunction : skew_tu

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   logic test_mode; // bypass test, style select at middle
   logic tr_active; // test reset requested
   logic [4:0] off_req; // disable requests, feedback bank last
   logic [4:0] hiz_req; // float request per bank
   logic [4:0] hold_req; // stop request per bank
   logic tr_hold_r; // test reset done, state held
   logic [2:0] tr_cnt_r; // reference edges during test reset
   assign test_mode = (output_mode_select == mbcd_pkg::TRI_MID);
   assign tr_active = test_mode && bank_off_request[3];
   assign off_req = {feedback_bank_off_request, bank_off_request};
   // bank disables neither float nor stop a bank in bypass, bank4's starts test reset; style select at middle there
   always_comb
   begin
      for (int b = 0; b < mbcd_pkg::NBANK; b++)
      begin
         hiz_req[b] = off_req[b] && (output_mode_select == mbcd_pkg::TRI_HIGH);
         hold_req[b] = off_req[b] && (output_mode_select == mbcd_pkg::TRI_LOW);
      end
   end

   // ----------------------------------------
   // sampled inputs and edges
   // ----------------------------------------
   logic src_level; // divider source level
   logic src_prev_r;
   logic ref_prev_r;
   logic fb_prev_r;
   logic src_edge; // either edge of the source
   logic ref_rise;
   logic fb_rise;
   // a style change may fake one source edge; style is static by contract
   assign src_level = test_mode ? ref_clk_level : vco_clk_level;
   assign src_edge = src_level != src_prev_r;
   assign ref_rise = ref_clk_level && !ref_prev_r;
   assign fb_rise = loop_return_input && !fb_prev_r;
   // edge history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_prev_r <= 1'b0;
         ref_prev_r <= 1'b0;
         fb_prev_r <= 1'b0;
      end
      else
      begin
         src_prev_r <= src_level;
         ref_prev_r <= ref_clk_level;
         fb_prev_r <= loop_return_input;
      end
   end

   // ----------------------------------------
   // test reset sequencing
   // ----------------------------------------
   // count reference rises while requested, then hold until release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tr_cnt_r <= 3'h0;
         tr_hold_r <= 1'b0;
      end
      else if (!tr_active)
      begin
         tr_cnt_r <= 3'h0;
         tr_hold_r <= 1'b0;
      end
      else if (ref_rise && !tr_hold_r)
      begin
         tr_cnt_r <= tr_cnt_r + 3'h1;
         tr_hold_r <= (tr_cnt_r + 3'h1) == mbcd_pkg::TEST_RESET_EDGES;
      end
   end

   // ----------------------------------------
   // dividers, one per bank
   // ----------------------------------------
   logic [4:0] ratio [mbcd_pkg::NBANK]; // divide ratio per bank
   logic [5:0] cnt_r [mbcd_pkg::NBANK]; // source transitions in period
   logic [5:0] cnt_nxt [mbcd_pkg::NBANK];
   logic [4:0] base_r; // divided clock before polarity
   logic [4:0] run_r; // bank running, not parked
   always_comb
   begin
      for (int b = 0; b < 4; b++)
         ratio[b] = div_ratio(bank_divide_select[b]);
      ratio[mbcd_pkg::FB_IDX] = div_ratio(feedback_divide_select);
      // both source edges counted, so odd ratios stay at half duty
      for (int b = 0; b < mbcd_pkg::NBANK; b++)
         cnt_nxt[b] = (cnt_r[b] == {ratio[b], 1'b0} - 6'h01) ? 6'h00 : cnt_r[b] + 6'h01;
   end
   // one counter drives every output of a bank
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int b = 0; b < mbcd_pkg::NBANK; b++)
            cnt_r[b] <= 6'h00;
         base_r <= 5'h00;
         run_r <= 5'h1f;
      end
      else
      begin
         for (int b = 0; b < mbcd_pkg::NBANK; b++)
         begin
            if (tr_hold_r)
            begin
               cnt_r[b] <= 6'h00;
               base_r[b] <= 1'b0;
               run_r[b] <= 1'b1;
            end
            else if (!run_r[b])
            begin
               // restart from a clean period once released
               if (!hold_req[b] || test_mode)
               begin
                  run_r[b] <= 1'b1;
                  cnt_r[b] <= 6'h00;
               end
            end
            else if (hold_req[b] && !test_mode && !base_r[b])
               run_r[b] <= 1'b0;
            else if (src_edge)
            begin
               cnt_r[b] <= cnt_nxt[b];
               base_r[b] <= {1'b0, cnt_nxt[b][4:0]} < {1'b0, ratio[b]};
            end
         end
      end
   end

   // ----------------------------------------
   // polarity and output drive
   // ----------------------------------------
   logic [3:0] b3_inv; // inversion mask: a0, a1, b0, b1
   always_comb
   begin
      unique case (bank3_polarity_select)
         mbcd_pkg::TRI_LOW: b3_inv = 4'ha;
         mbcd_pkg::TRI_HIGH: b3_inv = 4'hf;
         default: b3_inv = 4'h0;
      endcase
   end
   // inversion sits after the divider, so skew and ratio act unchanged
   always_comb
   begin
      for (int b = 0; b < 4; b++)
      begin
         bank_out[b] = {4{base_r[b]}} ^ ((b == 2) ? b3_inv : 4'h0);
         bank_oe[b] = test_mode ? !tr_active : !hiz_req[b];
      end
      feedback_out = {2{base_r[mbcd_pkg::FB_IDX]}};
      feedback_oe = test_mode ? !tr_active : !hiz_req[mbcd_pkg::FB_IDX];
   end

   // ----------------------------------------
   // effective skew, relative to the reference
   // ----------------------------------------
   logic signed [5:0] sk [mbcd_pkg::NBANK];
   logic signed [5:0] eff [4];
   always_comb
   begin
      sk[0] = skew_tu(bank_phase_select[0], 1'b0, 6'sh00, 6'sh00);
      sk[1] = skew_tu(bank_phase_select[1], 1'b0, 6'sh00, 6'sh00);
      sk[2] = skew_tu(bank_phase_select[2], 1'b1, sk[0], sk[1]);
      sk[3] = skew_tu(bank_phase_select[3], 1'b1, sk[0], sk[1]);
      // one feedback select drives both halves of the pair: -4, 0 or +4 units
      sk[4] = skew_tu('{hi: feedback_phase_select, lo: feedback_phase_select}, 1'b0,
                      6'sh00, 6'sh00);
      // the loop cancels the feedback skew, moving every bank the other way
      for (int b = 0; b < 4; b++)
         eff[b] = sk[b] - sk[mbcd_pkg::FB_IDX];
   end

   // ----------------------------------------
   // lock detector and watchdog
   // ----------------------------------------
   logic [15:0] limit_r; // phase window, pclk cycles
   logic [15:0] wdog_r; // watchdog timeout, reference rises
   logic [15:0] since_ref_r; // cycles since last reference rise
   logic [15:0] wd_cnt_r; // reference rises since last feedback rise
   logic [2:0] err_cnt_r;
   logic [5:0] good_cnt_r;
   logic lock_r;
   logic phase_err;
   // window measured from the latest reference rise; without a reference it means little
   assign phase_err = (ref_rise ? 16'h0000 : since_ref_r) > limit_r;
   // phase window timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         since_ref_r <= 16'h0000;
      else if (ref_rise)
         since_ref_r <= 16'h0001;
      else if (since_ref_r != 16'hffff)
         since_ref_r <= since_ref_r + 16'h0001;
   end
   // watchdog counts every reference rise between feedback rises
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wd_cnt_r <= 16'h0000;
      else if (fb_rise || tr_hold_r)
         wd_cnt_r <= 16'h0000;
      else if (ref_rise && wd_cnt_r != 16'hffff)
         wd_cnt_r <= wd_cnt_r + 16'h0001;
   end
   // run counters and lock state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_cnt_r <= 3'h0;
         good_cnt_r <= 6'h00;
         lock_r <= 1'b0;
      end
      else if (tr_hold_r)
      begin
         err_cnt_r <= 3'h0;
         good_cnt_r <= 6'h00;
         lock_r <= 1'b0;
      end
      else if (lock_r && wdog_r != 16'h0000 && wd_cnt_r >= wdog_r)
      begin
         lock_r <= 1'b0;
         good_cnt_r <= 6'h00;
      end
      else if (fb_rise)
      begin
         if (phase_err)
         begin
            good_cnt_r <= 6'h00;
            if (err_cnt_r != mbcd_pkg::LOCK_ERR_RUN)
               err_cnt_r <= err_cnt_r + 3'h1;
            if (err_cnt_r + 3'h1 >= mbcd_pkg::LOCK_ERR_RUN)
               lock_r <= 1'b0;
         end
         else
         begin
            err_cnt_r <= 3'h0;
            if (good_cnt_r != mbcd_pkg::LOCK_GOOD_RUN)
               good_cnt_r <= good_cnt_r + 6'h01;
            if (good_cnt_r + 6'h01 == mbcd_pkg::LOCK_GOOD_RUN)
               lock_r <= 1'b1;
         end
      end
   end
   assign lock_flag = lock_r;

   // ----------------------------------------
   // apb register file
   // ----------------------------------------
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [31:0] rd_data;
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = (paddr == mbcd_pkg::REG_CTRL) || (paddr == mbcd_pkg::REG_STATUS) ||
                   (paddr == mbcd_pkg::REG_SKEW) || (paddr == mbcd_pkg::REG_WDOG);
   // no wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   // writable controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         limit_r <= mbcd_pkg::PHASE_LIMIT_CYC;
         wdog_r <= mbcd_pkg::WDOG_RST;
      end
      else if (wr_en)
      begin
         if (paddr == mbcd_pkg::REG_CTRL)
            limit_r <= pwdata[15:0];
         if (paddr == mbcd_pkg::REG_WDOG)
            wdog_r <= pwdata[15:0];
      end
   end
   // read mux
   always_comb
   begin
      rd_data = 32'h0000_0000;
      if (paddr == mbcd_pkg::REG_CTRL)
         rd_data[15:0] = limit_r;
      else if (paddr == mbcd_pkg::REG_STATUS)
      begin
         rd_data[mbcd_pkg::ST_LOCK] = lock_r;
         rd_data[mbcd_pkg::ST_TEST] = test_mode;
         rd_data[mbcd_pkg::ST_TRHOLD] = tr_hold_r;
         rd_data[mbcd_pkg::ST_RUN_LSB +: 5] = run_r;
         rd_data[mbcd_pkg::ST_ERR_LSB +: 3] = err_cnt_r;
         rd_data[mbcd_pkg::ST_FS_LSB +: 2] = frequency_range_select;
      end
      else if (paddr == mbcd_pkg::REG_SKEW)
      begin
         for (int b = 0; b < 4; b++)
            rd_data[8 * b +: 8] = {{2{eff[b][5]}}, eff[b]};
      end
      else if (paddr == mbcd_pkg::REG_WDOG)
         rd_data[15:0] = wdog_r;
   end
   // read data captured in the setup cycle, stable through the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= rd_data;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_div_twelve;
      @(posedge pclk) disable iff (!presetn)
      (bank_divide_select[0] == '{hi: mbcd_pkg::TRI_HIGH, lo: mbcd_pkg::TRI_HIGH}) |->
         (ratio[0] == 5'h0c);
   endproperty
   a_div_twelve: assert property (p_div_twelve)
      else $error("high-high divide select not twelve");
   property p_hiz_now;
      @(posedge pclk) disable iff (!presetn)
      (off_req[1] && output_mode_select == mbcd_pkg::TRI_HIGH) |-> !bank_oe[1];
   endproperty
   a_hiz_now: assert property (p_hiz_now)
      else $error("bank not floated at once");
   property p_enabled;
      @(posedge pclk) disable iff (!presetn)
      (!test_mode && !off_req[0]) |-> bank_oe[0];
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("enabled bank not driving");
   property p_park_low;
      @(posedge pclk) disable iff (!presetn)
      !run_r[2] |-> !base_r[2] && (bank_out[2] == b3_inv);
   endproperty
   a_park_low: assert property (p_park_low)
      else $error("bank parked at wrong level");
   property p_pairs;
      @(posedge pclk) disable iff (!presetn)
      (bank3_polarity_select == mbcd_pkg::TRI_LOW) |->
         (bank_out[2][1] == !bank_out[2][0]) && (bank_out[2][3] == !bank_out[2][2]) &&
         (bank_out[2][0] == base_r[2]);
   endproperty
   a_pairs: assert property (p_pairs)
      else $error("bank3 pairs not complementary");
   property p_all_inv;
      @(posedge pclk) disable iff (!presetn)
      (bank3_polarity_select == mbcd_pkg::TRI_HIGH) |-> (bank_out[2] == {4{!base_r[2]}});
   endproperty
   a_all_inv: assert property (p_all_inv)
      else $error("bank3 not fully inverted");
   property p_lock_drop;
      @(posedge pclk) disable iff (!presetn)
      (lock_r && fb_rise && phase_err && err_cnt_r == 3'h3) |=> !lock_r;
   endproperty
   a_lock_drop: assert property (p_lock_drop)
      else $error("lock kept after four errors");
   property p_lock_rise;
      @(posedge pclk) disable iff (!presetn)
      $rose(lock_r) |-> ($past(good_cnt_r) == 6'h1f) && $past(fb_rise) && !$past(phase_err);
   endproperty
   a_lock_rise: assert property (p_lock_rise)
      else $error("lock raised before 32 clean cycles");
   property p_wdog;
      @(posedge pclk) disable iff (!presetn)
      (lock_r && wdog_r != 16'h0000 && wd_cnt_r >= wdog_r) |=> !lock_r;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("watchdog did not drop lock");
   property p_test_float;
      @(posedge pclk) disable iff (!presetn)
      tr_active |-> (bank_oe == 4'h0) && !feedback_oe;
   endproperty
   a_test_float: assert property (p_test_float)
      else $error("test reset left outputs driving");
   property p_hold_state;
      @(posedge pclk) disable iff (!presetn)
      tr_hold_r |=> (cnt_r[0] == 6'h00) && !lock_r || !tr_active;
   endproperty
   a_hold_state: assert property (p_hold_state)
      else $error("state not held during test reset");
endmodule : mbcd_top

/* src/mbcd_pkg.sv */
// shared types and constants of the multi-bank clock divider control
// assumes a 10 MHz pclk and three-level select pins already resolved to codes
package mbcd_pkg;
   // ----------------------------------------
   // three-level select codes
   // ----------------------------------------
   // code doubles as the level index 0..2
   typedef enum logic [1:0] {
      TRI_LOW = 2'b00,
      TRI_MID = 2'b01,
      TRI_HIGH = 2'b10
   } mbcd_tri_type;
   // a pair of selects, upper one first
   typedef struct packed {
      mbcd_tri_type hi;
      mbcd_tri_type lo;
   } mbcd_sel_pair_type;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   // phase window allowed between reference and feedback edges
   localparam int unsigned PHASE_LIMIT_NS = 300;
   // longest time, so rounded down
   localparam logic [15:0] PHASE_LIMIT_CYC = 16'(PHASE_LIMIT_NS / CLK_PERIOD_NS);
   // lock run lengths, in feedback cycles
   localparam logic [2:0] LOCK_ERR_RUN = 3'h4;
   localparam logic [5:0] LOCK_GOOD_RUN = 6'h20;
   // reference edges that complete a test reset
   localparam logic [2:0] TEST_RESET_EDGES = 3'h5;
   // watchdog timeout in reference edges after reset
   localparam logic [15:0] WDOG_RST = 16'h0040;
   // bank count, feedback bank last
   localparam int unsigned NBANK = 5;
   localparam int unsigned FB_IDX = 4;
   // ----------------------------------------
   // register map (byte offsets)
   // ----------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_SKEW = 12'h008;
   localparam logic [11:0] REG_WDOG = 12'h00c;
   // status field positions
   localparam int unsigned ST_LOCK = 0;
   localparam int unsigned ST_TEST = 1;
   localparam int unsigned ST_TRHOLD = 2;
   localparam int unsigned ST_RUN_LSB = 3;
   localparam int unsigned ST_ERR_LSB = 8;
   localparam int unsigned ST_FS_LSB = 11;
endpackage : mbcd_pkg

/* sim/mbcd_src_model.sv */
// partner model: oscillator, reference and return levels seen by the block
// assumes the block samples these levels on pclk
`timescale 1ns/1ns
module mbcd_src_model
(
   input wire logic pclk,
   input wire logic test_mode,
   input wire logic fb_on,
   input wire logic fb_late,
   output logic vco_lvl,
   output logic ref_lvl,
   output logic fb_lvl
);
   // ----
   // level generation
   // ----
   logic [3:0] cnt_r = 4'h0; // free phase counter
   // oscillator period 2 pclk, reference 16 pclk
   always @(posedge pclk)
   begin
      cnt_r <= cnt_r + 4'h1;
   end
   assign vco_lvl = cnt_r[0];
   assign ref_lvl = cnt_r[3];
   // return follows reference, or its inverse when late; held low in bypass test
   assign fb_lvl = (test_mode || !fb_on) ? 1'b0 : ref_lvl ^ fb_late;
endmodule : mbcd_src_model

/* sim/tb_top.sv */
// self-checking bench: apb, dividers, disables, polarity, lock, test reset
// assumes the partner model drives oscillator, reference and return levels
`timescale 1ns/1ns
module tb_top;
   // ----
   // signals
   // ----
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, fb_oe, lock_flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic vco, refl, fbl, fb_on, fb_late, fb_off;
   mbcd_pkg::mbcd_sel_pair_type [3:0] div_sel, ph_sel;
   mbcd_pkg::mbcd_tri_type pol_sel, fs_sel, mode_sel, fb_ph;
   logic [3:0] off_req, bank_oe;
   logic [3:0][3:0] bank_out;
   logic [1:0] fb_out;
   int mismatches = 0;
   int n_tests = 0;
   int n;
   logic [15:0] seed = 16'hdb94; // lfsr start
   logic [64:0] rq[$]; // expected reads: {error, mask, data}
   int rat[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
   logic [3:0] park[3] = '{4'ha, 4'h0, 4'hf}; // bank3 parked levels per polarity
   mbcd_top i_mbcd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vco_clk_level(vco), .ref_clk_level(refl),
      .loop_return_input(fbl), .bank_divide_select(div_sel), .bank_phase_select(ph_sel),
      .bank_off_request(off_req), .feedback_divide_select({2{mbcd_pkg::TRI_LOW}}),
      .feedback_phase_select(fb_ph), .feedback_bank_off_request(fb_off),
      .bank3_polarity_select(pol_sel), .frequency_range_select(fs_sel),
      .output_mode_select(mode_sel), .bank_out(bank_out), .bank_oe(bank_oe),
      .feedback_out(fb_out), .feedback_oe(fb_oe), .lock_flag(lock_flag));
   mbcd_src_model i_mbcd_src_model (.pclk(pclk), .test_mode(mode_sel == mbcd_pkg::TRI_MID),
      .fb_on(fb_on), .fb_late(fb_late), .vco_lvl(vco), .ref_lvl(refl), .fb_lvl(fbl));
   // ----
   // helpers
   // ----
   function automatic mbcd_pkg::mbcd_tri_type tp(input int v);
      return mbcd_pkg::mbcd_tri_type'(2'(v));
   endfunction : tp
   // next value of the stimulus lfsr
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic step(input int k);
      repeat (k) @(posedge pclk);
   endtask : step
   task automatic finish_test();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp_val
   // apb transfer; request held until pready seen, bounded wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [32:0] e);
      rq.push_back({e[32], m, e[31:0]});
      apb(1'b0, a, 32'h0);
   endtask : rd
   // bounded wait for a lock level
   task automatic wait_lock(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && lock_flag !== v; i++) @(posedge pclk);
      cmp_val(32'(lock_flag), 32'(v), "lock level");
      if (lock_flag !== v)
         finish_test();
   endtask : wait_lock
   // cycles between two rises of a bank output
   task automatic period(input int b);
      logic p;
      int r, i;
      p = bank_out[b][0];
      r = 0;
      n = 0;
      for (i = 0; i < 200 && r < 2; i++)
      begin
         @(posedge pclk);
         if (r == 1) n++;
         if (!p && bank_out[b][0] === 1'b1) r++;
         p = bank_out[b][0];
      end
   endtask : period
   // ----
   // read watcher: oldest expectation against each completed read
   // ----
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
      begin
         cmp_val(prdata & rq[0][63:32], rq[0][31:0], "read data");
         cmp_val(32'(pslverr), 32'(rq[0][64]), "slave error");
         void'(rq.pop_front());
      end
   end
   // ----
   // clock and main sequence
   // ----
   initial forever #50 pclk = ~pclk;
   initial
   begin
      {presetn, psel, penable, pwrite, fb_on, fb_late, fb_off, paddr, pwdata, off_req} = '0;
      div_sel = '0;
      ph_sel = '0;
      pol_sel = mbcd_pkg::TRI_MID;
      mode_sel = mbcd_pkg::TRI_LOW; // static except where a scenario switches it
      fs_sel = mbcd_pkg::TRI_LOW;
      fb_ph = mbcd_pkg::TRI_HIGH; // feedback output skewed by +4 units
      step(5);
      presetn <= 1'b1;
      seed = lfsr(seed);
      fs_sel <= tp(seed % 3);
      ph_sel[0] <= {tp(seed[7:0] % 3), tp(seed[15:8] % 3)};
      cmp_val(32'(lock_flag), 32'h0, "lock after reset");
      rd(mbcd_pkg::REG_CTRL, 32'hffff, 33'h3);
      rd(mbcd_pkg::REG_WDOG, 32'hffff, 33'h40);
      rd(12'h010, 32'hffffffff, 33'h100000000);
      rd(mbcd_pkg::REG_STATUS, 32'h1800, 33'(fs_sel) << 11);
      // bank1 random, banks 2-4 at -4/-8/-8, all pulled back by the feedback's +4
      n = 3 * (seed[7:0] % 3) + seed[15:8] % 3 - 8;
      rd(mbcd_pkg::REG_SKEW, 32'hffffffff, {9'h0f4, 16'hf4f8, 8'(n)});
      for (int i = 0; i < 9; i++)
      begin
         div_sel[0] <= {tp(i / 3), tp(i % 3)};
         step(26);
         period(0);
         cmp_val(32'(n), 32'(2 * rat[i]), "divide period");
      end
      div_sel[2] <= {tp(0), tp(1)};
      for (int p = 0; p < 3; p++)
      begin
         pol_sel <= tp(p);
         off_req[2] <= 1'b1;
         step(24);
         @(negedge pclk);
         cmp_val(32'(bank_out[2]), 32'(park[p]), "parked bank3");
         @(posedge pclk);
         off_req[2] <= 1'b0;
         step(8);
      end
      mode_sel <= mbcd_pkg::TRI_HIGH;
      off_req[1] <= 1'b1;
      fb_off <= 1'b1;
      @(negedge pclk);
      cmp_val(32'({bank_oe, fb_oe}), 32'h1a, "float bank2 and feedback");
      @(posedge pclk);
      off_req[1] <= 1'b0;
      fb_off <= 1'b0;
      fb_on <= 1'b1;
      wait_lock(1'b1, 1000);
      rd(mbcd_pkg::REG_STATUS, 32'h1, 33'h1);
      fb_late <= 1'b1; // return rises half a reference period late
      wait_lock(1'b0, 200);
      fb_late <= 1'b0;
      wait_lock(1'b1, 1000);
      apb(1'b1, mbcd_pkg::REG_WDOG, 32'h8);
      fb_on <= 1'b0;
      wait_lock(1'b0, 400);
      @(posedge pclk);
      mode_sel <= mbcd_pkg::TRI_MID;
      off_req[3] <= 1'b1;
      div_sel[0] <= '0;
      @(negedge pclk);
      cmp_val(32'({bank_oe, fb_oe}), 32'h0, "test reset float");
      step(90);
      rd(mbcd_pkg::REG_STATUS, 32'h7, 33'h6);
      cmp_val(32'(fb_out), 32'h0, "feedback held low");
      off_req <= 4'h1;
      step(3);
      rd(mbcd_pkg::REG_STATUS, 32'h6, 33'h2);
      @(negedge pclk);
      cmp_val(32'(bank_oe), 32'hf, "disable ignored in test");
      period(0);
      cmp_val(32'(n), 32'd16, "bypass period");
      finish_test();
   end
endmodule : tb_top
